// File: design/uim_defines.svh
`ifndef UIM_DEFINES_SVH
`define UIM_DEFINES_SVH

// Peripheral slot and register offsets
`define UIM_PERIPH_NUM    8'h01
`define UIM_OFS_RESET     8'h00
`define UIM_OFS_CTRL      8'h04
`define UIM_OFS_ADDR      8'h08
`define UIM_OFS_FUNC      8'h0C
`define UIM_OFS_OTG_CTRL  8'h10
`define UIM_OFS_OTG_STAT  8'h14
`define UIM_OFS_SERIAL    8'h18
`define UIM_OFS_FLAGS     8'h1C
`define UIM_OFS_HOLD      8'h20
`define UIM_OFS_MASKS     8'h24
`define UIM_OFS_SOF       8'h28
`define UIM_OFS_PID       8'h2C
`define UIM_OFS_EP        8'h30

// Engine control bits
`define UIM_CTRL_TOKEN_PROC  0
`define UIM_CTRL_TOKEN_CHECK 1
`define UIM_CTRL_LINE_DEC    2
`define UIM_CTRL_SOF_TOKEN   6
`define UIM_CTRL_WMASK       8'hF7

// Reset values
`define UIM_CTRL_RST    8'h00
`define UIM_FUNC_RST    5'h07
`define UIM_OTG_RST     7'h00
`define UIM_SER_RST     4'h2
`define UIM_FLAGS_RST   7'h00

// Flag bit positions
`define UIM_FLAG_TOKEN  6
`define UIM_FLAG_SE0    5
`define UIM_FLAG_K      4
`define UIM_FLAG_J      3
`define UIM_FLAG_CRC    2
`define UIM_FLAG_RXACT  1
`define UIM_FLAG_RXERR  0
`define UIM_FLAG_LEVEL  7'h3B

// Line states seen on the full-speed pair
`define UIM_LS_SE0      2'h0
`define UIM_LS_J        2'h1
`define UIM_LS_K        2'h2

// Packet identifiers and checks
`define UIM_PID_SOF     4'h5
`define UIM_PID_TOKEN   2'h1
`define UIM_PID_DATA    2'h3
`define UIM_CRC5_INIT   5'h1F
`define UIM_CRC5_POLY   5'h14
`define UIM_CRC5_RESID  5'h06
`define UIM_CRC16_INIT  16'hFFFF
`define UIM_CRC16_POLY  16'hA001
`define UIM_CRC16_RESID 16'hB001
`define UIM_TOKEN_BYTES 2'h2

`endif

// File: design/uim_pkg.sv
`include "uim_defines.svh"

package uim_pkg;

  typedef enum logic [4:0] {
    UIM_S_IDLE = 5'b00001,
    UIM_S_PID  = 5'b00010,
    UIM_S_TOK  = 5'b00100,
    UIM_S_DATA = 5'b01000,
    UIM_S_SKIP = 5'b10000
  } uim_dstate_t;

  typedef struct packed {
    logic [2:0] opmode;
    logic       termselect;
    logic       xcvrselect;
  } uim_func_ctrl_t;

  typedef struct packed {
    logic extvbusind;
    logic drvvbusext;
    logic chrgvbus;
    logic dischrgvbus;
    logic dmpulldown;
    logic dppulldown;
    logic idpullup;
  } uim_otg_ctrl_t;

  typedef struct packed {
    logic bvalid;
    logic idgnd;
    logic hostdis;
    logic vbusvld;
    logic sessvld;
    logic sessend;
  } uim_otg_stat_t;

  typedef struct packed {
    logic txse0;
    logic txdata;
    logic txenable_n;
    logic fslsserial;
  } uim_ser_ctrl_t;

  typedef struct packed {
    logic rxrcv;
    logic rxdm;
    logic rxdp;
  } uim_ser_stat_t;

  typedef struct packed {
    logic [7:0]     engine_mode_control;
    logic [6:0]     device_address;
    uim_func_ctrl_t func;
    uim_otg_ctrl_t  otg;
    uim_ser_ctrl_t  ser;
    logic [6:0]     flags;
    logic [6:0]     flag_hold_select;
    logic [31:0]    masks;
    logic [10:0]    sof;
    logic [3:0]     pid;
    logic [3:0]     ep;
    logic           ep_valid;
    logic [31:0]    rdata;
    logic           ack;
    logic [3:0]     ports;
  } uim_regs_t;

  typedef struct packed {
    uim_dstate_t st;
    logic [1:0]  nbytes;
    logic [7:0]  tok0;
    logic [7:0]  tok1;
    logic [4:0]  crc5;
    logic [15:0] crc16;
  } uim_dec_t;

  // Serial bus sends LSB first, so both checks run reflected
  function automatic logic [4:0] uim_crc5_byte(input logic [4:0] crc, input logic [7:0] d);
    logic [4:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (d[i] ^ c[0]) ? ((c >> 1) ^ `UIM_CRC5_POLY) : (c >> 1);
    end
    return c;
  endfunction : uim_crc5_byte

  function automatic logic [15:0] uim_crc16_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (d[i] ^ c[0]) ? ((c >> 1) ^ `UIM_CRC16_POLY) : (c >> 1);
    end
    return c;
  endfunction : uim_crc16_byte

  function automatic logic uim_mask_hit(input logic [6:0] flags, input logic [7:0] mask);
    return |(flags & mask[6:0]);
  endfunction : uim_mask_hit

endpackage : uim_pkg

// File: design/uim_usb_interface_module.sv
`include "uim_defines.svh"

module uim_usb_interface_module
  import uim_pkg::*;
(
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  // Peripheral register port
  input  wire logic           i_reg_wr,
  input  wire logic           i_reg_rd,
  input  wire logic [7:0]     i_reg_periph,
  input  wire logic [7:0]     i_reg_addr,
  input  wire logic [31:0]    i_reg_wdata,
  output logic      [31:0]    o_reg_rdata,
  output logic                o_reg_ack,
  // UTMI+ receive path, synchronous to i_clk
  input  wire logic [7:0]     i_utmi_data,
  input  wire logic           i_utmi_rxvalid,
  input  wire logic           i_utmi_rxactive,
  input  wire logic           i_utmi_rxerror,
  // UTMI+ slow status, asynchronous
  input  wire logic [1:0]     i_utmi_linestate,
  input  wire uim_otg_stat_t  i_otg_stat,
  input  wire uim_ser_stat_t  i_ser_stat,
  // UTMI+ control
  output uim_func_ctrl_t      o_phy_func,
  output uim_otg_ctrl_t       o_otg_ctrl,
  output uim_ser_ctrl_t       o_ser_ctrl,
  // Decoded token handoff
  output logic                o_token_strobe,
  output logic      [3:0]     o_token_pid,
  output logic      [3:0]     o_token_ep,
  // Flag ports
  output logic                o_flag_port_a,
  output logic                o_flag_port_b,
  output logic                o_flag_port_c,
  output logic                o_flag_port_d
);

  localparam int SYNC_W = 11;

  uim_regs_t r;
  uim_regs_t next_r;
  uim_dec_t  d;
  uim_dec_t  next_d;
  logic      [3:0] pid_q;
  logic      [3:0] next_pid_q;
  logic      tok_q;
  logic      next_tok_q;

  // Two-stage synchroniser for the slow PHY status lines
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [1:0]        ls_s;
  uim_otg_stat_t     otg_s;
  uim_ser_stat_t     ser_s;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {i_utmi_linestate, i_otg_stat, i_ser_stat};
      sync2 <= sync1;
    end
  end

  assign {ls_s, otg_s, ser_s} = sync2;

  // Bus decode
  logic acc;
  logic wr;
  logic soft_clr;

  assign acc      = (i_reg_wr | i_reg_rd) && (i_reg_periph == `UIM_PERIPH_NUM);
  assign wr       = i_reg_wr && (i_reg_periph == `UIM_PERIPH_NUM);
  assign soft_clr = wr && (i_reg_addr == `UIM_OFS_RESET);

  // Decoder events, valid for one cycle
  logic        pkt_start;
  logic        pid_ev;
  logic        tok_ev;
  logic        sof_ev;
  logic        crc_ev;
  logic [10:0] frame;
  logic        addr_ok;
  logic        crc5_ok;
  logic        is_sof;

  assign frame   = {d.tok1[2:0], d.tok0};
  assign addr_ok = d.tok0[6:0] == r.device_address;
  assign crc5_ok = d.crc5 == `UIM_CRC5_RESID;
  assign is_sof  = pid_q == `UIM_PID_SOF;

  always_comb begin
    next_d     = d;
    next_pid_q = pid_q;
    next_tok_q = 1'b0;
    pkt_start  = 1'b0;
    pid_ev     = 1'b0;
    tok_ev     = 1'b0;
    sof_ev     = 1'b0;
    crc_ev     = 1'b0;
    unique case (d.st)
      UIM_S_IDLE: begin
        if (i_utmi_rxactive) begin
          pkt_start = 1'b1;
          next_d.st = UIM_S_PID;
        end
      end
      UIM_S_PID: begin
        if (!i_utmi_rxactive) begin
          next_d.st = UIM_S_IDLE;
        end else if (i_utmi_rxvalid) begin
          next_d.nbytes = 2'h0;
          next_d.crc5   = `UIM_CRC5_INIT;
          next_d.crc16  = `UIM_CRC16_INIT;
          next_d.st     = UIM_S_SKIP;
          if (i_utmi_data[3:0] == ~i_utmi_data[7:4]) begin
            pid_ev     = 1'b1;
            next_pid_q = i_utmi_data[3:0];
            if (i_utmi_data[1:0] == `UIM_PID_TOKEN &&
                r.engine_mode_control[`UIM_CTRL_TOKEN_PROC]) begin
              next_d.st = UIM_S_TOK;
            end else if (i_utmi_data[1:0] == `UIM_PID_DATA) begin
              next_d.st = UIM_S_DATA;
            end
          end
        end
      end
      UIM_S_TOK: begin
        if (i_utmi_rxvalid && i_utmi_rxactive) begin
          next_d.crc5 = uim_crc5_byte(d.crc5, i_utmi_data);
          if (d.nbytes == 2'h0) begin
            next_d.tok0 = i_utmi_data;
          end else begin
            next_d.tok1 = i_utmi_data;
          end
          if (d.nbytes != 2'h3) begin
            next_d.nbytes = d.nbytes + 2'h1;
          end
        end
        if (!i_utmi_rxactive) begin
          next_d.st = UIM_S_IDLE;
          // Unchecked mode accepts any well-formed three-byte token
          if (d.nbytes == `UIM_TOKEN_BYTES &&
              (!r.engine_mode_control[`UIM_CTRL_TOKEN_CHECK] || crc5_ok)) begin
            if (is_sof) begin
              sof_ev = 1'b1;
              tok_ev = r.engine_mode_control[`UIM_CTRL_SOF_TOKEN];
            end else if (!r.engine_mode_control[`UIM_CTRL_TOKEN_CHECK] || addr_ok) begin
              tok_ev     = 1'b1;
              next_tok_q = 1'b1;
            end
          end
        end
      end
      UIM_S_DATA: begin
        if (i_utmi_rxvalid && i_utmi_rxactive) begin
          next_d.crc16 = uim_crc16_byte(d.crc16, i_utmi_data);
          if (d.nbytes != 2'h3) begin
            next_d.nbytes = d.nbytes + 2'h1;
          end
        end
        if (!i_utmi_rxactive) begin
          next_d.st = UIM_S_IDLE;
          crc_ev    = d.crc16 != `UIM_CRC16_RESID;
        end
      end
      UIM_S_SKIP: begin
        if (!i_utmi_rxactive) begin
          next_d.st = UIM_S_IDLE;
        end
      end
    endcase
    if (soft_clr) begin
      next_d.st  = UIM_S_IDLE;
      next_pid_q = 4'h0;
      next_tok_q = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      d     <= '{st: UIM_S_IDLE, nbytes: 2'h0, tok0: 8'h00, tok1: 8'h00,
                 crc5: `UIM_CRC5_INIT, crc16: `UIM_CRC16_INIT};
      pid_q <= 4'h0;
      tok_q <= 1'b0;
    end else begin
      d     <= next_d;
      pid_q <= next_pid_q;
      tok_q <= next_tok_q;
    end
  end

  // Flag sources in bit order 6..0
  logic [6:0] src;
  logic [6:0] clr;
  logic [6:0] keep;
  logic       line_en;

  assign line_en = r.engine_mode_control[`UIM_CTRL_LINE_DEC];
  always_comb begin
    src                   = 7'h00;
    src[`UIM_FLAG_TOKEN]  = tok_ev;
    src[`UIM_FLAG_SE0]    = line_en && ls_s == `UIM_LS_SE0;
    src[`UIM_FLAG_K]      = line_en && ls_s == `UIM_LS_K;
    src[`UIM_FLAG_J]      = line_en && ls_s == `UIM_LS_J;
    src[`UIM_FLAG_CRC]    = crc_ev;
    src[`UIM_FLAG_RXACT]  = i_utmi_rxactive;
    src[`UIM_FLAG_RXERR]  = i_utmi_rxerror;
  end

  assign clr  = (wr && i_reg_addr == `UIM_OFS_FLAGS) ? i_reg_wdata[6:0] : 7'h00;
  assign keep = pkt_start ? 7'h00 : (r.flags & ~clr);

  // Register file
  always_comb begin
    next_r       = r;
    next_r.ack   = acc;
    next_r.rdata = 32'h0000_0000;
    // Held bits: set beats a same-cycle clear
    next_r.flags = (r.flag_hold_select & ((r.flags & ~clr) | src)) |
                   (~r.flag_hold_select & `UIM_FLAG_LEVEL & src) |
                   (~r.flag_hold_select & ~`UIM_FLAG_LEVEL & (keep | src));
    next_r.ports = {uim_mask_hit(r.flags, r.masks[31:24]), uim_mask_hit(r.flags, r.masks[23:16]),
                    uim_mask_hit(r.flags, r.masks[15:8]), uim_mask_hit(r.flags, r.masks[7:0])};
    if (pid_ev) begin
      next_r.pid = next_pid_q;
    end
    if (sof_ev) begin
      next_r.sof = frame;
    end
    if (next_tok_q) begin
      next_r.ep       = {d.tok1[2:0], d.tok0[7]};
      next_r.ep_valid = 1'b1;
    end
    if (wr) begin
      unique case (i_reg_addr)
        `UIM_OFS_CTRL:     next_r.engine_mode_control = i_reg_wdata[7:0] & `UIM_CTRL_WMASK;
        `UIM_OFS_ADDR:     next_r.device_address = i_reg_wdata[6:0];
        `UIM_OFS_FUNC:     next_r.func = i_reg_wdata[4:0];
        `UIM_OFS_OTG_CTRL: next_r.otg = {i_reg_wdata[7:6], i_reg_wdata[4:0]};
        `UIM_OFS_SERIAL:   next_r.ser = i_reg_wdata[3:0];
        `UIM_OFS_HOLD:     next_r.flag_hold_select = i_reg_wdata[6:0];
        `UIM_OFS_MASKS:    next_r.masks = i_reg_wdata;
        `UIM_OFS_SOF:      next_r.sof = i_reg_wdata[10:0];
        default: ;
      endcase
    end
    if (acc && i_reg_rd) begin
      unique case (i_reg_addr)
        `UIM_OFS_CTRL:     next_r.rdata = {24'h0, r.engine_mode_control};
        `UIM_OFS_ADDR:     next_r.rdata = {25'h0, r.device_address};
        `UIM_OFS_FUNC:     next_r.rdata = {27'h0, r.func};
        `UIM_OFS_OTG_CTRL: next_r.rdata = {24'h0, r.otg[6:5], 1'b0, r.otg[4:0]};
        `UIM_OFS_OTG_STAT: next_r.rdata = {26'h0, otg_s};
        `UIM_OFS_SERIAL:   next_r.rdata = {25'h0, ser_s, r.ser};
        `UIM_OFS_FLAGS:    next_r.rdata = {25'h0, r.flags};
        `UIM_OFS_HOLD:     next_r.rdata = {25'h0, r.flag_hold_select};
        `UIM_OFS_MASKS:    next_r.rdata = r.masks;
        `UIM_OFS_SOF:      next_r.rdata = {21'h0, r.sof};
        `UIM_OFS_PID:      next_r.rdata = {28'h0, r.pid};
        `UIM_OFS_EP:       next_r.rdata = {27'h0, r.ep_valid, r.ep};
        default:           next_r.rdata = 32'h0000_0000;
      endcase
    end
    // PHY-facing controls survive so the link is not disturbed
    if (soft_clr) begin
      next_r.engine_mode_control = `UIM_CTRL_RST;
      next_r.device_address      = 7'h00;
      next_r.flags               = `UIM_FLAGS_RST;
      next_r.flag_hold_select    = 7'h00;
      next_r.masks               = 32'h0000_0000;
      next_r.sof                 = 11'h000;
      next_r.pid                 = 4'h0;
      next_r.ep                  = 4'h0;
      next_r.ep_valid            = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '{engine_mode_control: `UIM_CTRL_RST, device_address: 7'h00, func: `UIM_FUNC_RST,
             otg: `UIM_OTG_RST, ser: `UIM_SER_RST, flags: `UIM_FLAGS_RST, flag_hold_select: 7'h00,
             masks: 32'h0000_0000, sof: 11'h000, pid: 4'h0, ep: 4'h0, ep_valid: 1'b0,
             rdata: 32'h0000_0000, ack: 1'b0, ports: 4'h0};
    end else begin
      r <= next_r;
    end
  end

  assign o_reg_rdata    = r.rdata;
  assign o_reg_ack      = r.ack;
  assign o_phy_func     = r.func;
  assign o_otg_ctrl     = r.otg;
  assign o_ser_ctrl     = r.ser;
  assign o_token_strobe = tok_q;
  assign o_token_pid    = pid_q;
  assign o_token_ep     = r.ep;
  assign {o_flag_port_d, o_flag_port_c, o_flag_port_b, o_flag_port_a} = r.ports;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr(logic [7:0] a);
    i_reg_wr && i_reg_periph == `UIM_PERIPH_NUM && i_reg_addr == a;
  endsequence

  sequence s_token_end;
    d.st == UIM_S_TOK && !i_utmi_rxactive && d.nbytes == `UIM_TOKEN_BYTES && !soft_clr;
  endsequence

  chk_soft_clear: assert property (s_wr(`UIM_OFS_RESET) |=>
    r.flags == 7'h00 && r.pid == 4'h0 && !r.ep_valid && r.sof == 11'h000 && r.engine_mode_control == 8'h00)
    else $error("module reset left state behind");

  chk_ctrl_write: assert property (s_wr(`UIM_OFS_CTRL) |=>
    r.engine_mode_control == ($past(i_reg_wdata[7:0]) & `UIM_CTRL_WMASK))
    else $error("control write not stored");

  chk_token_addr: assert property (tok_ev && !is_sof && !soft_clr &&
    r.engine_mode_control[`UIM_CTRL_TOKEN_CHECK] |-> addr_ok ##1 o_token_strobe)
    else $error("token passed with foreign address");

  chk_opmode_drive: assert property (s_wr(`UIM_OFS_FUNC) |=>
    o_phy_func.opmode == $past(i_reg_wdata[4:2]) && o_phy_func.xcvrselect == $past(i_reg_wdata[0]))
    else $error("function controls not driven");

  chk_otg_status_read: assert property (i_reg_rd && acc && i_reg_addr == `UIM_OFS_OTG_STAT |=>
    o_reg_ack && o_reg_rdata[5:0] == $past(otg_s) && o_reg_rdata[31:6] == 26'h0)
    else $error("status read mismatch");

  chk_token_flag: assert property (s_token_end ##0 tok_ev |=> r.flags[`UIM_FLAG_TOKEN])
    else $error("token flag not set");

  chk_crc_flag: assert property (crc_ev && !soft_clr |=> r.flags[`UIM_FLAG_CRC] ##1 1'b1)
    else $error("crc flag not set");

  chk_rx_follow: assert property (!r.flag_hold_select[`UIM_FLAG_RXACT] && !soft_clr |=>
    r.flags[`UIM_FLAG_RXACT] == $past(i_utmi_rxactive))
    else $error("rx active flag not following");

  chk_sticky_hold: assert property (r.flag_hold_select[`UIM_FLAG_TOKEN] && r.flags[`UIM_FLAG_TOKEN] &&
    !clr[`UIM_FLAG_TOKEN] && !soft_clr |=> r.flags[`UIM_FLAG_TOKEN])
    else $error("held flag lost");

  chk_port_mask: assert property (1'b1 |=>
    o_flag_port_a == |($past(r.flags) & $past(r.masks[6:0])) &&
    o_flag_port_d == |($past(r.flags) & $past(r.masks[30:24])))
    else $error("flag port wrong");

  chk_sof_load: assert property (sof_ev && !wr |=> r.sof == $past(frame))
    else $error("frame count not loaded");

endmodule : uim_usb_interface_module

// File: dv/uim_phy_model.sv
module uim_phy_model
  import uim_pkg::*;
(
  // Clock
  input  wire logic    i_clk,
  // Receive path
  output logic [7:0]   o_data,
  output logic         o_rxvalid,
  output logic         o_rxactive,
  output logic         o_rxerror,
  // Slow status
  output logic [1:0]   o_linestate,
  output uim_otg_stat_t o_otg,
  output uim_ser_stat_t o_ser
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_data      = 8'hA5;
    o_rxvalid   = 1'b0;
    o_rxactive  = 1'b0;
    o_rxerror   = 1'b0;
    o_linestate = 2'h1;
    o_otg       = '0;
    o_ser       = '0;
  end

  // Idle gap keeps packets apart; bus shows junk outside valid bytes
  task automatic send(input logic [7:0] b [4], input int n);
    @(posedge i_clk);
    o_rxactive <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_rxvalid <= 1'b1;
      o_data    <= b[i];
    end
    @(posedge i_clk);
    o_rxvalid  <= 1'b0;
    o_rxactive <= 1'b0;
    o_data     <= ~b[n-1];
    repeat (3) @(posedge i_clk);
  endtask : send

  task automatic status(input logic [1:0] ls, input logic [5:0] ot, input logic [2:0] s, input logic e);
    @(posedge i_clk);
    o_linestate <= ls;
    o_otg       <= ot;
    o_ser       <= s;
    o_rxerror   <= e;
  endtask : status
endmodule : uim_phy_model

// File: dv/uim_usb_interface_module_tb.sv
module uim_usb_interface_module_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  pn = 8'h01;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic        ack;
  logic [7:0]  u_data;
  logic        u_vld, u_act, u_err;
  logic [1:0]  u_ls;
  logic [5:0]  u_otg;
  logic [2:0]  u_ser;
  logic [4:0]  func;
  logic [6:0]  otg_c;
  logic [3:0]  ser_c;
  logic        port_a, port_b, port_c, port_d;
  logic [63:0] expq[$];
  logic [63:0] e;
  logic        tstb;
  logic [3:0]  tpid, tep;
  logic [7:0]  tokq[$];
  logic [7:0]  te;
  logic        ack_d = 1'b0;
  logic        rd_d = 1'b0;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  integer      seed = 32'hEFDC;
  logic [6:0]  dev;
  logic [3:0]  ep;
  logic [5:0]  ot;
  logic [7:0]  pk [4];

  uim_usb_interface_module uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_periph(pn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .i_utmi_data(u_data),
    .i_utmi_rxvalid(u_vld), .i_utmi_rxactive(u_act), .i_utmi_rxerror(u_err),
    .i_utmi_linestate(u_ls), .i_otg_stat(u_otg), .i_ser_stat(u_ser),
    .o_phy_func(func), .o_otg_ctrl(otg_c), .o_ser_ctrl(ser_c),
    .o_token_strobe(tstb), .o_token_pid(tpid), .o_token_ep(tep),
    .o_flag_port_a(port_a), .o_flag_port_b(port_b),
    .o_flag_port_c(port_c), .o_flag_port_d(port_d));

  uim_phy_model phy (
    .i_clk(clk), .o_data(u_data), .o_rxvalid(u_vld), .o_rxactive(u_act),
    .o_rxerror(u_err), .o_linestate(u_ls), .o_otg(u_otg), .o_ser(u_ser));

  always #5 clk = ~clk;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic tally_and_finish;
    if (expq.size() != 0 || tokq.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Expected word and compare mask travel together to the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr   <= a;
    expq.push_back({m, d});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  function automatic logic [4:0] crc5(input logic [10:0] f);
    logic [4:0] c;
    c = 5'h1F;
    for (int i = 0; i < 11; i++) c = (f[i] ^ c[0]) ? ((c >> 1) ^ 5'h14) : (c >> 1);
    return ~c;
  endfunction : crc5

  // Accepted tokens note their expected PID and endpoint for the watcher
  task automatic tok(input logic [6:0] a, input logic [7:0] p = 8'hE1, input bit ok = 1'b0);
    logic [10:0] f;
    f = {ep, a};
    if (ok) tokq.push_back({p[3:0], ep});
    pk[0] = p;
    pk[1] = f[7:0];
    pk[2] = {crc5(f), f[10:8]};
    phy.send(pk, 3);
    repeat (2) @(posedge clk);
  endtask : tok

  always @(posedge clk) begin
    cmp(ack, ack_d);
    if (rd_d) begin
      e = expq.pop_front();
      cmp(rdata & e[63:32], e[31:0]);
    end
    if (tstb) begin
      te = (tokq.size() != 0) ? tokq.pop_front() : 8'hFF;
      cmp({tpid, tep}, te);
    end
    ack_d <= (reg_wr | reg_rd) && pn == 8'h01;
    rd_d  <= reg_rd && pn == 8'h01;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h7);
    rd(8'h18, 32'h2);
    rd(8'h08, 32'h0);
    #1;
    cmp(func, 32'h7);
    cmp(otg_c, 32'h0);
    $display("test reset done");
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'hF7);
    wr(8'h10, 32'hFFFFFFFF);
    wr(8'h0C, 32'h0);
    rd(8'h10, 32'hDF);
    rd(8'h0C, 32'h0);
    #1;
    cmp(otg_c, 32'h7F);
    cmp(func, 32'h0);
    ot = 6'($random(seed));
    phy.status(2'h1, ot, 3'h5, 1'b0);
    wr(8'h18, 32'hFFFFFFF5);
    repeat (4) @(posedge clk);
    rd(8'h18, 32'h55);
    rd(8'h14, {26'h0, ot});
    wr(8'h28, 32'hFFFFFFFF);
    rd(8'h28, 32'h7FF);
    wr(8'h14, 32'h0);
    rd(8'h14, {26'h0, ot});
    wr(8'h50, 32'hFF);
    rd(8'h50, 32'h0);
    #1;
    cmp(ser_c, 32'h5);
    $display("test registers done");
    wr(8'h00, $random(seed));
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'hDF);
    dev = 7'($random(seed)) | 7'h01;
    ep = 4'($random(seed));
    wr(8'h08, {25'h0, dev});
    pn <= 8'h02;
    wr(8'h08, 32'h0);
    pn <= 8'h01;
    rd(8'h08, {25'h0, dev});
    wr(8'h04, 32'h3);
    wr(8'h24, 32'h7F000440);
    tok(dev, 8'hE1, 1'b1);
    rd(8'h1C, 32'h40, 32'h44);
    rd(8'h2C, 32'h1);
    rd(8'h30, {27'h1, ep});
    #1;
    cmp(port_a, 32'h1);
    cmp(port_b, 32'h0);
    cmp(port_d, 32'h1);
    tok(dev ^ 7'h01);
    rd(8'h1C, 32'h0, 32'h40);
    wr(8'h20, 32'h40);
    tok(dev, 8'hE1, 1'b1);
    tok(dev ^ 7'h01);
    rd(8'h1C, 32'h40, 32'h40);
    wr(8'h1C, 32'h40);
    rd(8'h1C, 32'h0, 32'h40);
    $display("test tokens done");
    pk = '{8'hC3, 8'h01, 8'h02, 8'h03};
    phy.send(pk, 4);
    rd(8'h1C, 32'h4, 32'h4);
    rd(8'h2C, 32'h3);
    #1;
    cmp(port_b, 32'h1);
    cmp(port_c, 32'h0);
    wr(8'h04, 32'h43);
    tok(dev ^ 7'h01, 8'hA5);
    rd(8'h28, {21'h0, ep, dev ^ 7'h01});
    rd(8'h2C, 32'h5);
    rd(8'h1C, 32'h40, 32'h40);
    wr(8'h1C, 32'h40);
    wr(8'h04, 32'h1);
    tok(dev ^ 7'h01, 8'hE1, 1'b1);
    rd(8'h1C, 32'h40, 32'h40);
    wr(8'h04, 32'h7);
    for (int i = 0; i < 3; i++) begin
      phy.status(2'(i), ot, 3'h0, 1'b0);
      repeat (4) @(posedge clk);
      rd(8'h1C, 32'h20 >> (i == 0 ? 0 : 3 - i), 32'h38);
    end
    phy.status(2'h1, ot, 3'h0, 1'b1);
    repeat (4) @(posedge clk);
    rd(8'h1C, 32'h1, 32'h3);
    $display("test flags done");
    wr(8'h00, 32'h0);
    rd(8'h1C, 32'h0, 32'h7C);
    rd(8'h2C, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h08, 32'h0);
    repeat (3) @(posedge clk);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule : uim_usb_interface_module_tb
